// ### rtl/amci_pkg.sv
//==============================================================================
// Purpose: constants and types for the ascii meter command interpreter
// Assumes: one 10 MHz clock, byte stream from and to an outside uart
// Notes: baud code 0..7 = 1200..115200, parity code 0..4 = none,even,odd,mark,space
package amci_pkg;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int GAP_MS = 20;
	localparam int REC_S = 3;
	localparam int FLASH_MS = 50;
	localparam int TICK_S = 1;
	localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
	localparam int REC_CYC = CLK_HZ * REC_S;
	localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
	localparam int TICK_CYC = CLK_HZ * TICK_S;
	// framing characters
	localparam logic [7:0] CH_TERM = 8'h5E;
	localparam logic [7:0] CH_SEP = 8'h5F;
	localparam logic [7:0] CH_QM = 8'h3F;
	localparam logic [7:0] CH_ACK = 8'h41;
	localparam logic [7:0] CH_ERR = 8'h45;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_4 = 8'h34;
	localparam logic [7:0] CH_7 = 8'h37;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_N = 8'h6E;
	// commands and show styles
	localparam logic [7:0] CMD_ADDR = 8'h61;
	localparam logic [7:0] CMD_BAUD = 8'h42;
	localparam logic [7:0] CMD_BRI = 8'h62;
	localparam logic [7:0] CMD_SCL = 8'h43;
	localparam logic [7:0] CMD_MODEL = 8'h59;
	localparam logic [7:0] CMD_SER = 8'h5A;
	localparam logic [7:0] CMD_DISP = 8'h6D;
	localparam logic [7:0] CMD_ANN = 8'h4C;
	localparam logic [7:0] CMD_MSG = 8'h4D;
	localparam logic [7:0] CMD_USR = 8'h4E;
	localparam logic [7:0] CMD_SHOW = 8'h53;
	localparam logic [7:0] CMD_VER = 8'h56;
	localparam logic [7:0] STY_ON = 8'h53;
	localparam logic [7:0] STY_FLASH = 8'h46;
	localparam logic [7:0] STY_OFF = 8'h4F;
	// addressing and defaults
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] ADDR_MAX = 8'hF7;
	localparam logic [7:0] ADDR_DEF = 8'hFF;
	localparam logic [3:0] QM_RUN = 4'hC;
	localparam logic [2:0] BAUD_DEF = 3'h4;
	localparam logic [2:0] PAR_DEF = 3'h0;
	localparam logic [2:0] BRI_DEF = 3'h3;
	localparam int MAX_SECS = 3600;
	// field store and string sizes, in characters except FLD_N, which counts fields
	localparam int FLD_W = 8;
	localparam int FLD_N = 4;
	localparam int MSG_N = 4;
	localparam int DIG_N = 4;
	localparam int MODEL_N = 12;
	localparam int SER_N = 7;
	localparam int VER_N = 14;
	localparam int MEAS_N = 6;
	localparam int TXB_N = 40;
	// error codes
	localparam logic [3:0] ERR_UNK = 4'h1;
	localparam logic [3:0] ERR_CNT = 4'h4;
	localparam logic [3:0] ERR_LEN = 4'h5;
	localparam logic [3:0] ERR_P1 = 4'h6;
	localparam logic [3:0] ERR_P2 = 4'h7;
	localparam logic [3:0] ERR_P4 = 4'h9;
	localparam logic [3:0] ERR_NUM = 4'hA;
	localparam logic [3:0] ERR_OVF = 4'hB;
	localparam logic [3:0] ERR_TMO = 4'hC;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD = 3'b001,
		S_PARM = 3'b010,
		S_SKIP = 3'b011,
		S_EXEC = 3'b100,
		S_SEND = 3'b101
	} amci_state_t;

	typedef enum logic [3:0] {
		RSP_PLAIN = 4'b0000,
		RSP_BRI = 4'b0001,
		RSP_SCL = 4'b0010,
		RSP_USR = 4'b0011,
		RSP_TEXT = 4'b0100,
		RSP_ERR = 4'b0101
	} amci_rsp_t;
endpackage : amci_pkg

// ### rtl/amci_core.sv
//==============================================================================
// Purpose: ascii command interpreter of a panel meter, slave side of the link
// Assumes: bytes arrive and leave through an outside uart, 8 data 1 stop
// Notes: strings on text inputs are char 0 in bits 7:0, ended by a zero byte
`timescale 1ns/100ps
`default_nettype none
module amci_core #(
	parameter int GAP_CYC = amci_pkg::GAP_CYC,
	parameter int REC_CYC = amci_pkg::REC_CYC,
	parameter int FLASH_CYC = amci_pkg::FLASH_CYC,
	parameter int TICK_CYC = amci_pkg::TICK_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	input wire logic [8*amci_pkg::MODEL_N-1:0] modelText,
	input wire logic [8*amci_pkg::SER_N-1:0] serialText,
	input wire logic [8*amci_pkg::VER_N-1:0] versionText,
	input wire logic [8*amci_pkg::MEAS_N-1:0] measText,
	output logic [7:0] unitAddr,
	output logic addrEnabled,
	output logic recoveryMode,
	output logic [2:0] baudSel,
	output logic [2:0] paritySel,
	output logic [2:0] brightness,
	output logic annunEn,
	output logic annunFlash,
	output logic [191:0] scaleText,
	output logic [11:0] scaleLen,
	output logic scaleUpdate,
	output logic [31:0] msgText,
	output logic msgShow,
	output logic msgFlash,
	output logic nvStore
);
	//==========================================================================
	// helpers
	function automatic logic [7:0] byteAt(input logic [255:0] v, input int idx);
		byteAt = v[idx*8 +: 8];
	endfunction : byteAt

	function automatic logic isNumCh(input logic [7:0] c);
		isNumCh = (c >= amci_pkg::CH_0 && c <= amci_pkg::CH_9) || c == amci_pkg::CH_DOT
			|| c == amci_pkg::CH_MINUS || c == amci_pkg::CH_PLUS;
	endfunction : isNumCh

	function automatic logic numField(input logic [255:0] v, input logic [15:0] lens,
		input int f);
		numField = lens[f*4 +: 4] != 4'h0;
		for (int i = 0; i < amci_pkg::FLD_W; i++)
		begin
			if (i < int'(lens[f*4 +: 4]) && !isNumCh(byteAt(v, f*amci_pkg::FLD_W + i)))
				numField = 1'b0;
		end
	endfunction : numField

	//==========================================================================
	// state
	amci_pkg::amci_state_t state_r;
	amci_pkg::amci_rsp_t rsp;
	logic [7:0] cmdChar_r;
	logic bcast_r, ovf_r, badLen_r, timedOut_r, allQ_r, recov_r, pend_r, silent, go;
	logic [255:0] fld_r, usr_r;
	logic [15:0] fldLen_r, usrLen_r;
	logic [2:0] nF_r;
	logic [31:0] gap_r, flash_r, tick_r;
	logic [3:0] qCnt_r, errCode;
	logic [2:0] pBaud_r, pPar_r;
	logic [11:0] secs_r, showSecs;
	logic [7:0] txBuf [0:amci_pkg::TXB_N-1];
	logic [5:0] txLen_r, txIdx_r;
	logic addrOn, qHit, txDone;
	logic [7:0] b0, b1;
	logic [3:0] len0, len1;

	assign addrOn = !recov_r && unitAddr <= amci_pkg::ADDR_MAX;
	assign qHit = rxValid && rxData == amci_pkg::CH_QM && qCnt_r == amci_pkg::QM_RUN - 4'h1;
	assign txDone = state_r == amci_pkg::S_SEND && (!txValid || txReady) && txIdx_r == txLen_r;
	assign go = state_r == amci_pkg::S_EXEC && !silent && errCode == 4'h0;
	assign b0 = byteAt(fld_r, 0);
	assign b1 = byteAt(fld_r, amci_pkg::FLD_W);
	assign len0 = fldLen_r[3:0];
	assign len1 = fldLen_r[7:4];

	//==========================================================================
	// recovery: twelve question marks in a row, held until power cycle
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			qCnt_r <= 4'h0;
			recov_r <= 1'b0;
		end
		else if (rxValid)
		begin
			qCnt_r <= (rxData != amci_pkg::CH_QM || qHit) ? 4'h0 : qCnt_r + 4'h1;
			if (qHit)
				recov_r <= 1'b1;
		end
	end

	//==========================================================================
	// frame receiver: address, command, fields, gap timeout
	always_ff @(posedge mclk or negedge rstn)
	begin : rxFrame
		int fi;
		if (!rstn)
		begin
			state_r <= amci_pkg::S_IDLE;
			cmdChar_r <= 8'h00;
			{bcast_r, ovf_r, badLen_r, timedOut_r, allQ_r} <= 5'h00;
			fld_r <= '0;
			fldLen_r <= 16'h0000;
			nF_r <= 3'h0;
			gap_r <= 32'h00000000;
		end
		else
		begin
			fi = int'(nF_r) - 1;
			case (state_r)
			amci_pkg::S_IDLE:
				if (rxValid && !qHit)
				begin
					gap_r <= 32'h00000000;
					{bcast_r, ovf_r, badLen_r, timedOut_r} <= 4'h0;
					nF_r <= 3'h0;
					fldLen_r <= 16'h0000;
					allQ_r <= rxData == amci_pkg::CH_QM;
					if (!addrOn)
					begin
						cmdChar_r <= rxData;
						state_r <= amci_pkg::S_PARM;
					end
					else if (rxData == unitAddr || rxData == amci_pkg::ADDR_BCAST)
					begin
						bcast_r <= rxData == amci_pkg::ADDR_BCAST;
						state_r <= amci_pkg::S_CMD;
					end
					else
						state_r <= amci_pkg::S_SKIP;
				end
			amci_pkg::S_CMD, amci_pkg::S_PARM, amci_pkg::S_SKIP:
				if (qHit)
					state_r <= amci_pkg::S_IDLE;
				else if (rxValid)
				begin
					gap_r <= 32'h00000000;
					if (rxData != amci_pkg::CH_QM)
						allQ_r <= 1'b0;
					if (state_r == amci_pkg::S_SKIP)
					begin
						if (rxData == amci_pkg::CH_TERM)
							state_r <= amci_pkg::S_IDLE;
					end
					else if (state_r == amci_pkg::S_CMD)
					begin
						cmdChar_r <= rxData;
						state_r <= amci_pkg::S_PARM;
					end
					else if (rxData == amci_pkg::CH_TERM)
						state_r <= amci_pkg::S_EXEC;
					else if (rxData == amci_pkg::CH_SEP)
					begin
						if (int'(nF_r) == amci_pkg::FLD_N)
							ovf_r <= 1'b1;
						else
							nF_r <= nF_r + 3'h1;
					end
					else if (nF_r == 3'h0)
						badLen_r <= 1'b1; // text glued to the command character
					else if (int'(fldLen_r[fi*4 +: 4]) == amci_pkg::FLD_W)
						ovf_r <= 1'b1;
					else
					begin
						fld_r[(fi*amci_pkg::FLD_W + int'(fldLen_r[fi*4 +: 4]))*8 +: 8] <= rxData;
						fldLen_r[fi*4 +: 4] <= fldLen_r[fi*4 +: 4] + 4'h1;
					end
				end
				else if (gap_r >= 32'(recov_r ? REC_CYC - 1 : GAP_CYC - 1))
				begin
					// pure question mark runs and foreign frames die quietly
					if (state_r == amci_pkg::S_SKIP || allQ_r)
						state_r <= amci_pkg::S_IDLE;
					else
					begin
						timedOut_r <= 1'b1;
						state_r <= amci_pkg::S_EXEC;
					end
				end
				else
					gap_r <= gap_r + 32'h00000001;
			amci_pkg::S_EXEC:
				state_r <= silent ? amci_pkg::S_IDLE : amci_pkg::S_SEND;
			amci_pkg::S_SEND:
				if (txDone)
					state_r <= amci_pkg::S_IDLE;
			default:
				state_r <= amci_pkg::S_IDLE;
			endcase
		end
	end

	//==========================================================================
	// command decode: error code, reply kind, silence
	always_comb
	begin : decode
		int acc;
		logic ok;
		acc = 0;
		ok = len1 != 4'h0 && int'(len1) <= amci_pkg::DIG_N;
		for (int i = 0; i < amci_pkg::DIG_N; i++)
		begin
			if (i < int'(len1))
			begin
				if (!(byteAt(fld_r, amci_pkg::FLD_W + i) inside {[amci_pkg::CH_0:amci_pkg::CH_9]}))
					ok = 1'b0;
				acc = acc * 10 + int'(byteAt(fld_r, amci_pkg::FLD_W + i) - amci_pkg::CH_0);
			end
		end
		if (acc > amci_pkg::MAX_SECS)
			ok = 1'b0;
		showSecs = 12'(acc);
		errCode = 4'h0;
		rsp = amci_pkg::RSP_PLAIN;
		silent = 1'b0;
		if (timedOut_r)
		begin
			errCode = amci_pkg::ERR_TMO;
			silent = bcast_r;
		end
		else if (bcast_r && cmdChar_r != amci_pkg::CMD_VER)
			silent = 1'b1;
		else if (ovf_r)
			errCode = amci_pkg::ERR_OVF;
		else if (badLen_r)
			errCode = amci_pkg::ERR_LEN;
		else
			case (cmdChar_r)
			amci_pkg::CMD_ADDR:
				if (nF_r != 3'h1)
					errCode = amci_pkg::ERR_CNT;
				else if (len0 != 4'h1 || b0 == amci_pkg::ADDR_BCAST || b0 == amci_pkg::CH_TERM)
					errCode = amci_pkg::ERR_P1;
			amci_pkg::CMD_BAUD:
				if (nF_r != 3'h2)
					errCode = amci_pkg::ERR_CNT;
				else if (len0 != 4'h1 || !(b0 inside {[amci_pkg::CH_0:amci_pkg::CH_7]}))
					errCode = amci_pkg::ERR_P1;
				else if (len1 != 4'h1 || !(b1 inside {[amci_pkg::CH_0:amci_pkg::CH_4]}))
					errCode = amci_pkg::ERR_P2;
			amci_pkg::CMD_BRI:
				if (nF_r == 3'h0)
					rsp = amci_pkg::RSP_BRI;
				else if (nF_r != 3'h1)
					errCode = amci_pkg::ERR_CNT;
				else if (len0 != 4'h1 || !(b0 inside {[amci_pkg::CH_0:amci_pkg::CH_7]}))
					errCode = amci_pkg::ERR_P1;
			amci_pkg::CMD_SCL:
				if (nF_r == 3'h0)
					rsp = amci_pkg::RSP_SCL;
				else if (nF_r != 3'h3 && nF_r != 3'h4)
					errCode = amci_pkg::ERR_CNT;
				else if (nF_r == 3'h4 && (fldLen_r[15:12] != 4'h1
					|| byteAt(fld_r, 3*amci_pkg::FLD_W) != amci_pkg::CH_N))
					errCode = amci_pkg::ERR_P4;
				else if (!numField(fld_r, fldLen_r, 0) || !numField(fld_r, fldLen_r, 1)
					|| !numField(fld_r, fldLen_r, 2))
					errCode = amci_pkg::ERR_NUM;
			amci_pkg::CMD_MODEL, amci_pkg::CMD_SER, amci_pkg::CMD_DISP, amci_pkg::CMD_VER:
				if (nF_r != 3'h0)
					errCode = amci_pkg::ERR_CNT;
				else
					rsp = amci_pkg::RSP_TEXT;
			amci_pkg::CMD_ANN:
				if (nF_r != 3'h1)
					errCode = amci_pkg::ERR_CNT;
				else if (len0 != 4'h1 || (b0 != amci_pkg::CH_0 && b0 != amci_pkg::CH_1))
					errCode = amci_pkg::ERR_P1;
			amci_pkg::CMD_MSG:
				if (nF_r != 3'h1)
					errCode = amci_pkg::ERR_CNT;
				else if (int'(len0) != amci_pkg::MSG_N)
					errCode = amci_pkg::ERR_P1;
			amci_pkg::CMD_USR:
				if (nF_r == 3'h0)
					rsp = amci_pkg::RSP_USR;
				else if (int'(nF_r) != amci_pkg::FLD_N)
					errCode = amci_pkg::ERR_CNT;
				else if (!numField(fld_r, fldLen_r, 0) || !numField(fld_r, fldLen_r, 1)
					|| !numField(fld_r, fldLen_r, 2) || !numField(fld_r, fldLen_r, 3))
					errCode = amci_pkg::ERR_NUM;
			amci_pkg::CMD_SHOW:
				if (nF_r != 3'h2)
					errCode = amci_pkg::ERR_CNT;
				else if (len0 != 4'h1 || !(b0 inside {amci_pkg::STY_ON, amci_pkg::STY_FLASH,
					amci_pkg::STY_OFF}))
					errCode = amci_pkg::ERR_P1;
				else if (!ok)
					errCode = amci_pkg::ERR_P2;
			default:
				errCode = amci_pkg::ERR_UNK;
			endcase
		if (errCode != 4'h0)
			rsp = amci_pkg::RSP_ERR;
	end

	//==========================================================================
	// settings, only on a clean command
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			unitAddr <= amci_pkg::ADDR_DEF;
			{baudSel, pBaud_r} <= {2{amci_pkg::BAUD_DEF}};
			{paritySel, pPar_r} <= {2{amci_pkg::PAR_DEF}};
			brightness <= amci_pkg::BRI_DEF;
			annunEn <= 1'b1;
			pend_r <= 1'b0;
			{scaleText, scaleLen, usr_r, usrLen_r, msgText} <= '0;
			{scaleUpdate, nvStore} <= 2'b00;
		end
		else
		begin
			scaleUpdate <= 1'b0;
			nvStore <= go && cmdChar_r inside {amci_pkg::CMD_ADDR, amci_pkg::CMD_ANN}
				|| go && nF_r != 3'h0 && cmdChar_r inside {amci_pkg::CMD_BRI, amci_pkg::CMD_USR}
				|| go && nF_r == 3'h4 && cmdChar_r == amci_pkg::CMD_SCL
				|| txDone && pend_r;
			if (txDone && pend_r)
			begin
				baudSel <= pBaud_r;
				paritySel <= pPar_r;
				pend_r <= 1'b0;
			end
			if (go)
				case (cmdChar_r)
				amci_pkg::CMD_ADDR: unitAddr <= b0;
				amci_pkg::CMD_BAUD:
				begin
					pBaud_r <= 3'(b0 - amci_pkg::CH_0);
					pPar_r <= 3'(b1 - amci_pkg::CH_0);
					pend_r <= 1'b1;
				end
				amci_pkg::CMD_BRI:
					if (nF_r != 3'h0)
						brightness <= 3'(b0 - amci_pkg::CH_0);
				amci_pkg::CMD_SCL:
					if (nF_r != 3'h0)
					begin
						scaleText <= fld_r[191:0];
						scaleLen <= fldLen_r[11:0];
						scaleUpdate <= 1'b1;
					end
				amci_pkg::CMD_ANN: annunEn <= b0 == amci_pkg::CH_1;
				amci_pkg::CMD_MSG: msgText <= fld_r[31:0];
				amci_pkg::CMD_USR:
					if (nF_r != 3'h0)
					begin
						usr_r <= fld_r;
						usrLen_r <= fldLen_r;
					end
				default: ;
				endcase
		end
	end

	//==========================================================================
	// message display timing, one second tick
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			{msgShow, msgFlash} <= 2'b00;
			secs_r <= 12'h000;
			tick_r <= 32'h00000000;
		end
		else if (go && cmdChar_r == amci_pkg::CMD_SHOW)
		begin
			msgShow <= b0 != amci_pkg::STY_OFF;
			msgFlash <= b0 == amci_pkg::STY_FLASH;
			secs_r <= showSecs;
			tick_r <= 32'h00000000;
		end
		else if (tick_r == 32'(TICK_CYC - 1))
		begin
			tick_r <= 32'h00000000;
			if (msgShow && secs_r != 12'h000)
			begin
				secs_r <= secs_r - 12'h001;
				if (secs_r == 12'h001)
					{msgShow, msgFlash} <= 2'b00; // back to the meter reading
			end
		end
		else
			tick_r <= tick_r + 32'h00000001;
	end

	//==========================================================================
	// annunciator flash, registered status outputs
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			flash_r <= 32'h00000000;
			{annunFlash, addrEnabled, recoveryMode} <= 3'b000;
		end
		else
		begin
			addrEnabled <= addrOn;
			recoveryMode <= recov_r;
			if (state_r == amci_pkg::S_EXEC && !silent && annunEn)
			begin
				flash_r <= 32'(FLASH_CYC - 1);
				annunFlash <= 1'b1;
			end
			else if (flash_r != 32'h00000000)
				flash_r <= flash_r - 32'h00000001;
			else
				annunFlash <= 1'b0;
		end
	end

	//==========================================================================
	// reply builder, one cycle in exec
	always_ff @(posedge mclk)
	begin : build
		int p;
		logic live;
		logic [255:0] src;
		int n;
		p = 0;
		live = 1'b1;
		src = '0;
		n = 0;
		if (state_r == amci_pkg::S_EXEC && !silent)
		begin
			if (addrOn)
			begin
				txBuf[p] <= unitAddr;
				p = p + 1;
			end
			if (rsp == amci_pkg::RSP_ERR)
			begin
				txBuf[p] <= amci_pkg::CH_ERR;
				txBuf[p+1] <= amci_pkg::CH_SEP;
				if (errCode >= amci_pkg::ERR_NUM)
				begin
					txBuf[p+2] <= amci_pkg::CH_1;
					txBuf[p+3] <= amci_pkg::CH_0 + 8'(errCode - amci_pkg::ERR_NUM);
					p = p + 4;
				end
				else
				begin
					txBuf[p+2] <= amci_pkg::CH_0 + 8'(errCode);
					p = p + 3;
				end
			end
			else
			begin
				txBuf[p] <= amci_pkg::CH_ACK;
				p = p + 1;
				if (rsp == amci_pkg::RSP_BRI)
				begin
					txBuf[p] <= amci_pkg::CH_SEP;
					txBuf[p+1] <= amci_pkg::CH_0 + 8'(brightness);
					p = p + 2;
				end
				else if (rsp == amci_pkg::RSP_SCL || rsp == amci_pkg::RSP_USR)
				begin
					n = (rsp == amci_pkg::RSP_SCL) ? 3 : amci_pkg::FLD_N;
					for (int f = 0; f < amci_pkg::FLD_N; f++)
						if (f < n)
						begin
							txBuf[p] <= amci_pkg::CH_SEP;
							p = p + 1;
							for (int i = 0; i < amci_pkg::FLD_W; i++)
								if (rsp == amci_pkg::RSP_SCL ? i < int'(scaleLen[f*4 +: 4])
									: i < int'(usrLen_r[f*4 +: 4]))
								begin
									txBuf[p] <= byteAt(rsp == amci_pkg::RSP_SCL ?
										256'(scaleText) : usr_r, f*amci_pkg::FLD_W + i);
									p = p + 1;
								end
						end
				end
				else if (rsp == amci_pkg::RSP_TEXT)
				begin
					case (cmdChar_r)
					amci_pkg::CMD_MODEL: src = 256'(modelText);
					amci_pkg::CMD_SER: src = 256'(serialText);
					amci_pkg::CMD_DISP: src = 256'(measText);
					default: src = 256'(versionText);
					endcase
					txBuf[p] <= amci_pkg::CH_SEP;
					p = p + 1;
					for (int i = 0; i < amci_pkg::VER_N; i++)
					begin
						if (byteAt(src, i) == 8'h00)
							live = 1'b0;
						if (live)
						begin
							txBuf[p] <= byteAt(src, i);
							p = p + 1;
						end
					end
				end
			end
			txBuf[p] <= amci_pkg::CH_TERM;
			txLen_r <= 6'(p + 1);
		end
	end

	//==========================================================================
	// byte sender, valid/ready toward the uart
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			txData <= 8'h00;
			txValid <= 1'b0;
			txIdx_r <= 6'h00;
		end
		else if (state_r == amci_pkg::S_EXEC)
			txIdx_r <= 6'h00;
		else if (state_r == amci_pkg::S_SEND && (!txValid || txReady))
		begin
			if (txIdx_r == txLen_r)
				txValid <= 1'b0;
			else
			begin
				txData <= txBuf[txIdx_r];
				txValid <= 1'b1;
				txIdx_r <= txIdx_r + 6'h01;
			end
		end
	end
endmodule : amci_core
`default_nettype wire

// ### test/amci_host.sv
// Purpose: serial host side of amci_core, takes reply bytes
// Assumes: stall slows acceptance
// Notes: every accepted byte lands in rxq
`timescale 1ns/100ps
`default_nettype none
module amci_host (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic stall,
	output logic txReady
);
	logic [7:0] rxq[$];
	//====
	// 8-bit characters; stall accepts one cycle in two
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			txReady <= 1'b0;
		else
			txReady <= stall ? !txReady : 1'b1;
	// gather reply bytes
	always @(posedge mclk)
		if (rstn && txValid && txReady)
			rxq.push_back(txData);
endmodule : amci_host
`default_nettype wire

// ### test/amci_monitor.sv
// Purpose: port checks of amci_core
// Assumes: bound to every amci_core
// Notes: one clock domain
`timescale 1ns/100ps
`default_nettype none
module amci_monitor (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic [7:0] unitAddr,
	input wire logic addrEnabled,
	input wire logic recoveryMode,
	input wire logic [2:0] baudSel,
	input wire logic scaleUpdate,
	input wire logic nvStore
);
	//====
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("reply byte lost");
	a_reply_open: assert property ($rose(txValid) |-> txData == amci_pkg::CH_ACK
		|| txData == amci_pkg::CH_ERR || addrEnabled)
		else $error("bad reply opener");
	a_addr_mode: assert property (1 |=> addrEnabled ==
		($past(unitAddr) <= 8'hF7 && !recoveryMode))
		else $error("address mode wrong");
	a_addr_legal: assert property (unitAddr != 8'h00 && unitAddr != 8'h5E)
		else $error("illegal unit address");
	a_recov_keep: assert property (recoveryMode |=> recoveryMode)
		else $error("recovery left");
	a_baud_late: assert property ($changed(baudSel) |->
		$past(txValid && txReady && txData == amci_pkg::CH_TERM))
		else $error("baud changed early");
	a_scale_pulse: assert property (scaleUpdate |=> !scaleUpdate)
		else $error("scale pulse long");
	a_nv_pulse: assert property (nvStore |=> !nvStore)
		else $error("store pulse long");
endmodule : amci_monitor
bind amci_core amci_monitor u_mon (.mclk(mclk), .rstn(rstn), .txData(txData),
	.txValid(txValid), .txReady(txReady), .unitAddr(unitAddr), .addrEnabled(addrEnabled),
	.recoveryMode(recoveryMode), .baudSel(baudSel), .scaleUpdate(scaleUpdate), .nvStore(nvStore));
`default_nettype wire

// ### test/ascii_meter_command_interpreter_tb.sv
// Purpose: directed bench of amci_core
// Assumes: short timing parameters
// Notes: replies gathered by amci_host
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected %0t value", $time); end end
module ascii_meter_command_interpreter_tb;
	localparam logic [8:0] NA = 9'h000;
	localparam logic [8:0] A21 = 9'h121;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] rxData = 8'h00;
	logic rxValid = 1'b0;
	logic stall = 1'b0;
	logic [7:0] txData, unitAddr;
	logic txValid, txReady, addrEnabled, recoveryMode, annunEn, msgShow, msgFlash;
	logic annunFlash, nvStore;
	logic flashQ = 1'b0;
	logic [11:0] scaleLen;
	logic [191:0] scaleText;
	logic [31:0] msgText;
	int flashN = 0;
	int nvN = 0;
	logic [2:0] baudSel, paritySel, brightness;
	int error_cnt = 0;
	int n_tests = 0;
	int gapc = 2;
	always #50 mclk = ~mclk;
	amci_core #(.GAP_CYC(50), .REC_CYC(200), .FLASH_CYC(10), .TICK_CYC(20)) u_dut (
		.mclk(mclk), .rstn(rstn), .rxData(rxData), .rxValid(rxValid), .txData(txData),
		.txValid(txValid), .txReady(txReady), .modelText(96'("21-MP")),
		.serialText("7654321"), .versionText(112'("1V")), .measText(48'("2.06-")),
		.unitAddr(unitAddr), .addrEnabled(addrEnabled), .recoveryMode(recoveryMode),
		.baudSel(baudSel), .paritySel(paritySel), .brightness(brightness), .annunEn(annunEn),
		.annunFlash(annunFlash), .scaleText(scaleText), .scaleLen(scaleLen), .scaleUpdate(),
		.msgText(msgText), .msgShow(msgShow), .msgFlash(msgFlash), .nvStore(nvStore));
	amci_host u_host (.mclk(mclk), .rstn(rstn), .txData(txData), .txValid(txValid),
		.stall(stall), .txReady(txReady));
	// count flash starts and store strobes
	always @(posedge mclk)
	begin
		if (annunFlash && !flashQ)
			flashN++;
		if (nvStore)
			nvN++;
		flashQ <= annunFlash;
	end
	//====
	// verdict and end of run
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// one character after gapc idle cycles
	task automatic put(input logic [7:0] c);
		repeat (gapc) @(posedge mclk);
		#1 rxData = c;
		rxValid = 1'b1;
		@(posedge mclk);
		#1 rxValid = 1'b0;
	endtask : put
	// frame out, whole reply in before the next; bit 8 marks an address byte
	task automatic cmd(input logic [8:0] ad, input logic [8:0] rp, input string s,
		input string e);
		logic [7:0] q[$];
		int i;
		u_host.rxq.delete();
		if (ad[8]) put(ad[7:0]);
		foreach (s[k]) put(s[k]);
		if (rp[8]) q.push_back(rp[7:0]);
		foreach (e[k]) q.push_back(e[k]);
		for (i = 0; i < 400 && q.size() > 0; i++)
		begin
			@(posedge mclk);
			if (u_host.rxq.size() >= q.size() && !txValid) break;
		end
		if (i == 400)
		begin
			error_cnt++;
			finish_test();
		end
		repeat (80) @(posedge mclk);
		`CHK(u_host.rxq.size(), q.size())
		foreach (q[k]) `CHK(u_host.rxq[k], q[k])
	endtask : cmd
	//====
	// main sequence
	initial
	begin
		string s;
		repeat (6) @(posedge mclk);
		#1 rstn = 1'b1;
		`CHK(unitAddr, 8'hFF)
		`CHK({baudSel, paritySel, brightness}, 9'h103)
		`CHK({annunEn, addrEnabled}, 2'h2)
		cmd(NA, NA, "b^", "A_3^");
		#1 stall = 1'b1;
		cmd(NA, NA, "b_7^", "A^");
		#1 stall = 1'b0;
		cmd(NA, NA, "b_8^", "E_6^");
		cmd(NA, NA, "Q^", "E_1^");
		`CHK(brightness, 3'h7)
		cmd(NA, NA, "Y^", "A_PM-12^");
		cmd(NA, NA, "Z^", "A_1234567^");
		cmd(NA, NA, "m^", "A_-60.2^");
		cmd(NA, NA, "C_1.5_-2_30^", "A^");
		`CHK({scaleLen, scaleText[23:0]}, 36'h223352E31)
		cmd(NA, NA, "C^", "A_1.5_-2_30^");
		cmd(NA, NA, "N_1_2_3_4^", "A^");
		cmd(NA, NA, "N^", "A_1_2_3_4^");
		cmd(NA, NA, "L_0^", "A^");
		`CHK(annunEn, 1'b0)
		cmd(NA, NA, "M_P?En^", "A^");
		`CHK(msgText, 32'h6E453F50)
		`CHK(msgShow, 1'b0)
		cmd(NA, NA, "S_F_0^", "A^");
		`CHK({msgShow, msgFlash}, 2'h3)
		cmd(NA, NA, "S_O_0^", "A^");
		`CHK(msgShow, 1'b0)
		cmd(NA, NA, "S_S_1^", "A^");
		`CHK(msgShow, 1'b0)
		cmd(NA, NA, "b_1_2^", "E_4^");
		cmd(NA, NA, "bx^", "E_5^");
		cmd(NA, NA, "B_0_5^", "E_7^");
		cmd(NA, NA, "C_1_2_3_x^", "E_9^");
		cmd(NA, NA, "N_1_2_3_a^", "E_10^");
		cmd(NA, NA, "C_123456789^", "E_11^");
		`CHK({brightness, scaleLen}, 15'h7223)
		for (int b = 7; b >= 0; b--)
		begin
			s = "B_0_0^";
			s[2] = 8'h30 + b;
			s[4] = 8'h30 + b % 5;
			cmd(NA, NA, s, "A^");
			`CHK({baudSel, paritySel}, {3'(b), 3'(b % 5)})
		end
		cmd(NA, NA, "a_!^", "A^");
		`CHK({unitAddr, addrEnabled}, 9'h043)
		cmd(A21, A21, "b^", "A_7^");
		cmd(NA, NA, "b^", "");
		cmd(9'h100, NA, "b^", "");
		cmd(9'h100, A21, "V^", "A_V1^");
		cmd(9'h122, NA, "V^", "");
		cmd(A21, A21, "b", "E_12^");
		cmd(NA, NA, "????????????", "");
		`CHK({recoveryMode, addrEnabled}, 2'h2)
		gapc = 100;
		cmd(NA, NA, "b^", "A_7^");
		`CHK(flashN, 12)
		`CHK(nvN, 12)
		finish_test();
	end
endmodule : ascii_meter_command_interpreter_tb
`default_nettype wire
